// [hdl/ledmx_regs.svh]
// constants for the led display multiplex and dimmer block
`ifndef LEDMX_REGS_SVH
`define LEDMX_REGS_SVH
`define LEDMX_PRESCALE 4'd12
`define LEDMX_PRESCALE_LAST 4'd11
`define LEDMX_RELOAD_DEFAULT 16'hFF00
`define LEDMX_SLOT_COUNTS 9'd256
`define LEDMX_COUNT_PERIOD_NS 2000
`define LEDMX_SLOT_US 512
`define LEDMX_TIMER_MAX 16'hFFFF
`define LEDMX_NUM_DIGITS 4
`define LEDMX_LEAD_SLOT 2'd0
`define LEDMX_LEAD_MASK 7'h0F
`define LEDMX_GATE_TICKS 32'd500000
`endif

// [hdl/ledmx_pkg.sv]
// types for the led display multiplex and dimmer block
package ledmx_pkg;
  // segment pattern for one digit
  typedef logic [6:0] ledmx_seg_t;
  // outputs to the digit and segment drivers
  typedef struct packed {
    logic [3:0] digit_select_outputs;
    ledmx_seg_t segment_outputs;
  } ledmx_drive_t;
  // timer events, one-cycle pulses
  typedef struct packed {
    logic overflow;
    logic compare;
  } ledmx_evt_t;
  // slot index, gray coded along the scan
  typedef enum logic [1:0] {
    LEDMX_SLOT0 = 2'b00,
    LEDMX_SLOT1 = 2'b01,
    LEDMX_SLOT2 = 2'b11,
    LEDMX_SLOT3 = 2'b10
  } ledmx_slot_t;
endpackage : ledmx_pkg

// [hdl/ledmx_top.sv]
// led display multiplexer with brightness compare and speed pulse counter
// Summary of operation
// - timer counts once per twelve clocks
// - overflow reloads timer from reload value
// - overflows 256 counts apart, 512 us slots
// - four digit selects go high in turn
// - overflow event presents next pattern and digit
// - segments hold pattern while digit active
// - compare match raises event, blanks digits
// - blanking lasts until next overflow
// - compare value may change any time
// - leading digit uses only four segments
// - count speed pulses over fixed gate
`timescale 1ns/1ps
`include "ledmx_regs.svh"
module ledmx_top import ledmx_pkg::*; #(
  parameter logic [15:0] RELOAD = `LEDMX_RELOAD_DEFAULT,
  parameter logic [31:0] GATE_TICKS = `LEDMX_GATE_TICKS,
  parameter int CNT_W = 16
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [15:0] compare_value,
  input wire ledmx_seg_t digit_pattern [`LEDMX_NUM_DIGITS],
  input wire logic speed_pulse,
  output ledmx_drive_t drive,
  output ledmx_evt_t events,
  output logic [15:0] timer_value,
  output logic [CNT_W-1:0] speed_count,
  output logic speed_valid
);
  logic [3:0] pre_reg; // prescaler
  logic tick; // one prescaled count
  logic [15:0] timer_reg; // multiplex timer
  logic ovf; // overflow this cycle
  logic cmp_hit; // compare match this cycle
  ledmx_slot_t slot_reg; // current digit slot
  ledmx_slot_t slot_next;
  logic [3:0] sel_reg; // digit selects
  ledmx_seg_t seg_reg; // segment register
  logic blank_reg; // blanked until overflow
  logic ovf_reg; // registered events
  logic cmp_reg;
  logic [1:0] spd_sync_reg; // pin synchroniser
  logic spd_last_reg; // edge detect
  logic [31:0] gate_reg; // gate timer
  logic [CNT_W-1:0] pcnt_reg; // running pulse count
  logic [CNT_W-1:0] spd_reg; // latched result
  logic spd_valid_reg;

  // slot index to one-hot select
  function automatic logic [3:0] slot_onehot(input ledmx_slot_t s);
    case (s)
      LEDMX_SLOT0: slot_onehot = 4'h1;
      LEDMX_SLOT1: slot_onehot = 4'h2;
      LEDMX_SLOT2: slot_onehot = 4'h4;
      default: slot_onehot = 4'h8;
    endcase
  endfunction : slot_onehot

  // slot index to digit position in the pattern array
  function automatic logic [1:0] slot_digit(input ledmx_slot_t s);
    case (s)
      LEDMX_SLOT0: slot_digit = 2'd0;
      LEDMX_SLOT1: slot_digit = 2'd1;
      LEDMX_SLOT2: slot_digit = 2'd2;
      default: slot_digit = 2'd3;
    endcase
  endfunction : slot_digit

  // prescaler, divide by twelve
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pre_reg <= 4'h0;
    end else if (pre_reg == `LEDMX_PRESCALE_LAST) begin
      pre_reg <= 4'h0;
    end else begin
      pre_reg <= pre_reg + 4'h1;
    end
  end
  assign tick = (pre_reg == `LEDMX_PRESCALE_LAST);
  assign ovf = tick && (timer_reg == `LEDMX_TIMER_MAX);
  // compare seen on the counted value; new value takes effect at once
  assign cmp_hit = tick && (timer_reg == compare_value);

  // timer with auto-reload
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      timer_reg <= `LEDMX_RELOAD_DEFAULT;
    end else if (ovf) begin
      timer_reg <= RELOAD;
    end else if (tick) begin
      timer_reg <= timer_reg + 16'h1;
    end
  end

  // next slot in gray order, wraps after the fourth
  always_comb begin
    case (slot_reg)
      LEDMX_SLOT0: slot_next = LEDMX_SLOT1;
      LEDMX_SLOT1: slot_next = LEDMX_SLOT2;
      LEDMX_SLOT2: slot_next = LEDMX_SLOT3;
      default: slot_next = LEDMX_SLOT0;
    endcase
  end

  // slot advance on each overflow
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      slot_reg <= LEDMX_SLOT3;
    end else if (ovf) begin
      slot_reg <= slot_next;
    end
  end

  // segment data latched with the slot change; held whole slot
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      seg_reg <= 7'h00;
    end else if (ovf) begin
      if (slot_digit(slot_next) == `LEDMX_LEAD_SLOT) begin
        // leading digit drives only four segment lines
        seg_reg <= digit_pattern[`LEDMX_LEAD_SLOT] & `LEDMX_LEAD_MASK;
      end else begin
        seg_reg <= digit_pattern[slot_digit(slot_next)];
      end
    end
  end

  // blank flag: set by compare, cleared by overflow (overflow wins)
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      blank_reg <= 1'b1;
    end else if (ovf) begin
      blank_reg <= 1'b0;
    end else if (cmp_hit) begin
      blank_reg <= 1'b1;
    end
  end

  // digit selects, one high at a time unless blanked
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sel_reg <= 4'h0;
    end else if (ovf) begin
      sel_reg <= slot_onehot(slot_next);
    end else if (cmp_hit) begin
      sel_reg <= 4'h0;
    end
  end

  // event pulses
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ovf_reg <= 1'b0;
      cmp_reg <= 1'b0;
    end else begin
      ovf_reg <= ovf;
      cmp_reg <= cmp_hit;
    end
  end

  // speed pin synchroniser; first stage read only by second
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      spd_sync_reg <= 2'b00;
      spd_last_reg <= 1'b0;
    end else begin
      spd_sync_reg <= {spd_sync_reg[0], speed_pulse};
      spd_last_reg <= spd_sync_reg[1];
    end
  end

  // gated pulse counter; saturates rather than wrapping
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      gate_reg <= 32'h0;
      pcnt_reg <= '0;
      spd_reg <= '0;
      spd_valid_reg <= 1'b0;
    end else begin
      spd_valid_reg <= 1'b0;
      if (gate_reg == GATE_TICKS - 32'h1) begin
        gate_reg <= 32'h0;
        spd_reg <= pcnt_reg;
        spd_valid_reg <= 1'b1;
        pcnt_reg <= {{(CNT_W-1){1'b0}}, spd_sync_reg[1] & ~spd_last_reg};
      end else begin
        gate_reg <= gate_reg + 32'h1;
        if (spd_sync_reg[1] && !spd_last_reg && pcnt_reg != '1) begin
          pcnt_reg <= pcnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  assign drive.digit_select_outputs = sel_reg;
  assign drive.segment_outputs = seg_reg;
  assign events.overflow = ovf_reg;
  assign events.compare = cmp_reg;
  assign timer_value = timer_reg;
  assign speed_count = spd_reg;
  assign speed_valid = spd_valid_reg;

  // clocks between overflows, helper for the spacing check only
  // limitation: the expected gap assumes the default reload value
  localparam int SLOT_CLKS = `LEDMX_SLOT_COUNTS * `LEDMX_PRESCALE;
  logic [11:0] ovf_gap_reg; // clocks since last overflow
  logic ovf_seen_reg; // first overflow has happened
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ovf_gap_reg <= 12'h000;
      ovf_seen_reg <= 1'b0;
    end else if (ovf) begin
      ovf_gap_reg <= 12'h000;
      ovf_seen_reg <= 1'b1;
    end else if (ovf_gap_reg != 12'hFFF) begin
      // saturate so a lost overflow cannot wrap into a pass
      ovf_gap_reg <= ovf_gap_reg + 12'h001;
    end
  end

  // assertions
  sequence s_ovf;
    ovf && ovf_seen_reg;
  endsequence
  a_prescale_step: assert property (@(posedge clock) disable iff (!nrst)
    tick |=> !tick [*8] ##1 !tick [*3] ##1 tick) else $error("prescale not twelve");
  a_reload_value: assert property (@(posedge clock) disable iff (!nrst)
    ovf |=> timer_reg == RELOAD) else $error("reload wrong");
  a_slot_spacing: assert property (@(posedge clock) disable iff (!nrst)
    s_ovf |-> ovf_gap_reg == 12'(SLOT_CLKS - 1)) else $error("overflow spacing wrong");
  a_one_digit: assert property (@(posedge clock) disable iff (!nrst)
    $onehot0(sel_reg)) else $error("more than one digit");
  a_ovf_select: assert property (@(posedge clock) disable iff (!nrst)
    ovf |=> sel_reg == slot_onehot(slot_reg) && ovf_reg) else $error("select missing");
  a_seg_hold: assert property (@(posedge clock) disable iff (!nrst)
    !ovf |=> $stable(seg_reg)) else $error("segments moved mid slot");
  a_cmp_blank: assert property (@(posedge clock) disable iff (!nrst)
    (cmp_hit && !ovf) |=> sel_reg == 4'h0 && cmp_reg) else $error("compare no blank");
  a_blank_hold: assert property (@(posedge clock) disable iff (!nrst)
    (sel_reg == 4'h0 && !ovf) |=> sel_reg == 4'h0) else $error("unblanked early");
  a_blank_flag: assert property (@(posedge clock) disable iff (!nrst)
    blank_reg |-> sel_reg == 4'h0) else $error("digit lit while blanked");
  a_lead_mask: assert property (@(posedge clock) disable iff (!nrst)
    sel_reg[0] |-> seg_reg[6:4] == 3'h0) else $error("lead digit extra segment");
  a_slot_wrap: assert property (@(posedge clock) disable iff (!nrst)
    (ovf && slot_reg == LEDMX_SLOT3) |=> slot_reg == LEDMX_SLOT0) else $error("no wrap");
endmodule : ledmx_top

// [verification/ledmx_led_driver.sv]
// behavioural digit driver transistors on the display side; segment outputs are not modelled
`timescale 1ns/1ps
module ledmx_led_driver import ledmx_pkg::*; (
  input wire ledmx_drive_t drive,
  output logic [1:0] lit_digit,
  output logic lit_any
);
  // a digit conducts only while its select line is high
  always_comb begin
    lit_any = |drive.digit_select_outputs;
    lit_digit = 2'd0;
    for (int k = 0; k < 4; k++) begin
      if (drive.digit_select_outputs[k]) begin
        lit_digit = k[1:0];
      end
    end
  end
endmodule : ledmx_led_driver

// [verification/led_display_multiplex_dimmer_test.sv]
// self-checking bench for the led multiplex and dimmer block
`timescale 1ns/1ps
module led_display_multiplex_dimmer_test;
  import ledmx_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] compare_value = 16'h0000;
  ledmx_seg_t digit_pattern [4];
  logic speed_pulse = 1'b0;
  ledmx_drive_t drive;
  ledmx_evt_t events;
  logic [15:0] timer_value;
  logic [15:0] speed_count;
  logic speed_valid;
  logic [1:0] lit_digit;
  logic lit_any;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [31:0] rnd = 32'h07B487D8;
  // model state: slot index, clocks since overflow, blank flag
  int slot_idx = 3;
  int clk_since = -1;
  bit blanked = 1'b1;
  bit cmp_seen = 1'b0;
  bit cmp_due = 1'b0;
  logic [6:0] exp_seg = 7'h00;
  // stimulus applied in a slot shows up one overflow later
  ledmx_seg_t pat_prev [4];
  bit due_prev = 1'b0;
  int n_p;
  always #10 clock = ~clock;
  ledmx_top #(.GATE_TICKS(32'd100)) ledmx_top_inst (.clock(clock), .nrst(nrst),
    .compare_value(compare_value), .digit_pattern(digit_pattern), .speed_pulse(speed_pulse),
    .drive(drive), .events(events), .timer_value(timer_value), .speed_count(speed_count),
    .speed_valid(speed_valid));
  ledmx_led_driver ledmx_led_driver_inst (.drive(drive), .lit_digit(lit_digit),
    .lit_any(lit_any));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  // bounded wait for overflow event (0) or speed result (1)
  task automatic wait_for(input int which, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge clock);
      #1;
      if ((which == 0 ? events.overflow : speed_valid) === 1'b1) break;
    end
    if (i == lim) begin
      n_mismatch++;
      $display("[ERR] wait expected event seen none");
      results();
    end
  endtask : wait_for
  // reference model, compared every clock on the falling edge where outputs are settled
  always @(negedge clock) begin
    if (nrst) begin
      if (clk_since >= 0) clk_since++;
      if (events.overflow === 1'b1) begin
        if (clk_since >= 0) check("slot length", clk_since, 3072);
        if (clk_since >= 0) check("compare event", cmp_seen, due_prev);
        check("reload value", timer_value, 16'hFF00);
        clk_since = 0;
        slot_idx = (slot_idx + 1) % 4;
        blanked = 1'b0;
        cmp_seen = 1'b0;
        exp_seg = pat_prev[slot_idx] & (slot_idx == 0 ? 7'h0F : 7'h7F);
        pat_prev = digit_pattern;
        due_prev = cmp_due;
      end
      if (events.compare === 1'b1) begin
        blanked = 1'b1;
        cmp_seen = 1'b1;
        // event follows the matching count, timer has moved on by one
        check("compare time", timer_value, compare_value + 16'h1);
      end
      check("lit any", lit_any, !blanked);
      check("digit select", drive.digit_select_outputs, blanked ? 0 : 1 << slot_idx);
      if (!blanked) check("segments", drive.segment_outputs, exp_seg);
      if (!blanked) check("lit digit", lit_digit, slot_idx);
    end
  end
  // stimulus: dimming slots then speed gates
  initial begin
    for (int k = 0; k < 4; k++) digit_pattern[k] = 7'h7F;
    pat_prev = digit_pattern;
    repeat (16) @(posedge clock);
    #1 nrst = 1'b1;
    for (int s = 0; s < 10; s++) begin
      wait_for(0, 3200);
      rnd = xs(rnd);
      for (int k = 0; k < 4; k++) digit_pattern[k] = rnd[7*k +: 7];
      // last slot uses an unreachable value, full brightness
      compare_value = (s == 9) ? 16'h0010 : {8'hFF, 8'h01 + {1'b0, rnd[30:24]}};
      cmp_due = (s != 9);
      $display("slot test %0d done", s);
    end
    for (int g = 0; g < 3; g++) begin
      wait_for(1, 300);
      rnd = xs(rnd);
      n_p = rnd % 20;
      for (int p = 0; p < n_p; p++) begin
        speed_pulse = 1'b1;
        repeat (2) @(posedge clock);
        #1 speed_pulse = 1'b0;
        repeat (2) @(posedge clock);
        #1;
      end
      wait_for(1, 300);
      check("speed count", speed_count, n_p);
      $display("speed test %0d done", g);
    end
    results();
  end
endmodule : led_display_multiplex_dimmer_test
